/* core/ber_core.sv */
// Bridge error reporting with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module ber_core (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire ber_pkg::ber_perr_t perr_evt,
   input wire logic pw_target_abort,
   input wire logic pw_master_abort,
   input wire logic pw_discard,
   input wire logic dw_discard,
   input wire logic dr_fail,
   input wire logic master_timeout,
   input wire logic sec_system_err_n,
   output logic sec_parity_err_n,
   output logic pri_system_err_n
);
   logic [1:0] cmd, next_cmd;
   logic [2:0] bctl, next_bctl;
   logic sig_serr, next_sig_serr;
   logic rcv_serr, next_rcv_serr;
   logic [ber_pkg::NEV-1:0] cause, next_cause;
   logic [ber_pkg::NEV-1:0] dis, next_dis;
   logic sperr_q, next_sperr_q;
   logic pserr_q, next_pserr_q;
   logic sserr_m, sserr_s;
   logic aw_full, next_aw_full, w_full, next_w_full;
   logic [7:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic bvalid, next_bvalid;
   logic [1:0] bresp, next_bresp;
   logic rvalid, next_rvalid;
   logic [1:0] rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   logic sperr_cond, p_par, fwd;
   logic [ber_pkg::NEV-1:0] ev, ev_en;
   logic wr_go, cmd_perr, bctl_perr;

   // Two-flop synchroniser for the secondary system error pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sserr_m <= 1'b0;
         sserr_s <= 1'b0;
      end else begin
         sserr_m <= ~sec_system_err_n;
         sserr_s <= sserr_m;
      end
   end

   assign cmd_perr = cmd[ber_pkg::CMD_PERR_EN];
   assign bctl_perr = bctl[ber_pkg::BCTL_PERR_EN];

   // Error decision
   always_comb begin
      sperr_cond = 1'b0;
      p_par = 1'b0;
      if (perr_evt.valid) begin
         if (perr_evt.kind == ber_pkg::BER_RD && !perr_evt.upstream && perr_evt.on_sec
               && !perr_evt.as_target) begin
            sperr_cond = bctl_perr;
         end else if (perr_evt.kind == ber_pkg::BER_PW && perr_evt.upstream
               && perr_evt.on_sec && perr_evt.as_target) begin
            sperr_cond = bctl_perr;
         end else if (perr_evt.kind == ber_pkg::BER_DW && perr_evt.upstream
               && perr_evt.on_sec && perr_evt.as_target) begin
            sperr_cond = bctl_perr;
         end else if (perr_evt.kind == ber_pkg::BER_DW && perr_evt.upstream
               && !perr_evt.on_sec && perr_evt.completion_rpt) begin
            sperr_cond = bctl_perr && cmd_perr;
         end else begin
            sperr_cond = 1'b0;
         end
         // Target-bus report on posted write
         if (perr_evt.kind == ber_pkg::BER_PW && !perr_evt.as_target
               && (perr_evt.upstream != perr_evt.on_sec)) begin
            p_par = cmd_perr && bctl_perr;
         end
      end
      ev = '0;
      ev[ber_pkg::EV_PAR] = p_par;
      ev[ber_pkg::EV_TABT] = pw_target_abort;
      ev[ber_pkg::EV_MABT] = pw_master_abort;
      ev[ber_pkg::EV_PWDISC] = pw_discard;
      ev[ber_pkg::EV_DWDISC] = dw_discard;
      ev[ber_pkg::EV_DRFAIL] = dr_fail;
      ev[ber_pkg::EV_MTO] = master_timeout && bctl[ber_pkg::BCTL_MTO_SERR];
      fwd = sserr_s && bctl[ber_pkg::BCTL_SERR_FWD];
      ev[ber_pkg::EV_FWD] = fwd;
      ev_en = ev & ~dis;
      ev_en[ber_pkg::EV_MTO] = ev[ber_pkg::EV_MTO];
      ev_en[ber_pkg::EV_FWD] = ev[ber_pkg::EV_FWD];
      if (!cmd[ber_pkg::CMD_SERR_EN]) begin
         ev_en = '0;
      end
   end

   assign wr_go = aw_full && w_full && !bvalid;

   // Registers, outputs and bus state
   always_comb begin
      next_cmd = cmd;
      next_bctl = bctl;
      next_dis = dis;
      next_sig_serr = sig_serr;
      next_rcv_serr = rcv_serr;
      next_cause = cause;
      next_aw_full = aw_full;
      next_aw_addr = aw_addr;
      next_w_full = w_full;
      next_w_data = w_data;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      next_sperr_q = sperr_cond;
      next_pserr_q = |ev_en;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_full = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_full = 1'b1;
         next_w_data = s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (wr_go) begin
         next_aw_full = 1'b0;
         next_w_full = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = 2'b00;
         if (aw_addr == ber_pkg::ADDR_CMD) begin
            next_cmd = w_data[1:0];
         end else if (aw_addr == ber_pkg::ADDR_BCTL) begin
            next_bctl = w_data[2:0];
         end else if (aw_addr == ber_pkg::ADDR_STAT) begin
            if (w_data[ber_pkg::STAT_SIG_SERR]) next_sig_serr = 1'b0;
         end else if (aw_addr == ber_pkg::ADDR_SSTAT) begin
            if (w_data[ber_pkg::SSTAT_RCV_SERR]) next_rcv_serr = 1'b0;
         end else if (aw_addr == ber_pkg::ADDR_CAUSE) begin
            next_cause = cause & ~w_data[ber_pkg::NEV-1:0];
         end else if (aw_addr == ber_pkg::ADDR_DIS) begin
            next_dis = w_data[ber_pkg::NEV-1:0];
         end else begin
            next_bresp = 2'b10;
         end
      end
      // Hardware set wins over software clear
      if (|ev_en) begin
         next_sig_serr = 1'b1;
         next_cause = next_cause | ev_en;
      end
      if (sserr_s) begin
         next_rcv_serr = 1'b1;
      end
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = 2'b00;
         next_rdata = 32'h0000_0000;
         if (s_axi_araddr == ber_pkg::ADDR_CMD) begin
            next_rdata[1:0] = cmd;
         end else if (s_axi_araddr == ber_pkg::ADDR_BCTL) begin
            next_rdata[2:0] = bctl;
         end else if (s_axi_araddr == ber_pkg::ADDR_STAT) begin
            next_rdata[ber_pkg::STAT_SIG_SERR] = sig_serr;
         end else if (s_axi_araddr == ber_pkg::ADDR_SSTAT) begin
            next_rdata[ber_pkg::SSTAT_RCV_SERR] = rcv_serr;
         end else if (s_axi_araddr == ber_pkg::ADDR_CAUSE) begin
            next_rdata[ber_pkg::NEV-1:0] = cause;
         end else if (s_axi_araddr == ber_pkg::ADDR_DIS) begin
            next_rdata[ber_pkg::NEV-1:0] = dis;
         end else begin
            next_rresp = 2'b10;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd <= '0;
         bctl <= '0;
         dis <= '0;
         sig_serr <= 1'b0;
         rcv_serr <= 1'b0;
         cause <= '0;
         sperr_q <= 1'b0;
         pserr_q <= 1'b0;
         aw_full <= 1'b0;
         aw_addr <= 8'h00;
         w_full <= 1'b0;
         w_data <= ber_pkg::RST_ZERO;
         bvalid <= 1'b0;
         bresp <= 2'b00;
         rvalid <= 1'b0;
         rresp <= 2'b00;
         rdata <= ber_pkg::RST_ZERO;
      end else begin
         cmd <= next_cmd;
         bctl <= next_bctl;
         dis <= next_dis;
         sig_serr <= next_sig_serr;
         rcv_serr <= next_rcv_serr;
         cause <= next_cause;
         sperr_q <= next_sperr_q;
         pserr_q <= next_pserr_q;
         aw_full <= next_aw_full;
         aw_addr <= next_aw_addr;
         w_full <= next_w_full;
         w_data <= next_w_data;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
      end
   end

   assign s_axi_awready = !aw_full;
   assign s_axi_wready = !w_full;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_arready = !rvalid;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rresp = rresp;
   assign s_axi_rdata = rdata;
   assign sec_parity_err_n = ~sperr_q;
   assign pri_system_err_n = ~pserr_q;
   // Lock logic lives elsewhere; this block never touches lock state

   // Checks
   AST_R1: assert property (@(posedge aclk) disable iff (!aresetn)
      (perr_evt.valid && perr_evt.kind == ber_pkg::BER_RD && !perr_evt.upstream
       && perr_evt.on_sec && !perr_evt.as_target && bctl_perr) |=> !sec_parity_err_n)
      else $error("secondary parity error missing on read");
   AST_R4: assert property (@(posedge aclk) disable iff (!aresetn)
      (perr_evt.valid && perr_evt.kind == ber_pkg::BER_DW && perr_evt.completion_rpt
       && perr_evt.upstream && !perr_evt.on_sec && !cmd_perr) |=> sec_parity_err_n)
      else $error("secondary parity error without primary response");
   AST_R5: assert property (@(posedge aclk) disable iff (!aresetn)
      !perr_evt.valid |=> sec_parity_err_n)
      else $error("secondary parity error without event");
   AST_R7: assert property (@(posedge aclk) disable iff (!aresetn)
      (perr_evt.valid && perr_evt.as_target && ev[7:1] == '0) |=> pri_system_err_n)
      else $error("system error on own target parity detection");
   AST_R9: assert property (@(posedge aclk) disable iff (!aresetn)
      !cmd[ber_pkg::CMD_SERR_EN] |=> pri_system_err_n)
      else $error("system error while disabled");
   AST_R10: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(pri_system_err_n) |-> sig_serr)
      else $error("signaled flag not set");
   AST_R12: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(sec_system_err_n) ##2 1'b1 |=> rcv_serr)
      else $error("received flag not set");
   AST_R13: assert property (@(posedge aclk) disable iff (!aresetn)
      (pw_target_abort && cmd[ber_pkg::CMD_SERR_EN] && !dis[ber_pkg::EV_TABT])
      |=> !pri_system_err_n && cause[ber_pkg::EV_TABT])
      else $error("target abort not reported");
   AST_R20: assert property (@(posedge aclk) disable iff (!aresetn)
      (ev == 8'h04 && dis[ber_pkg::EV_MABT]) |=> pri_system_err_n)
      else $error("disabled event reported");
   AST_R20B: assert property (@(posedge aclk) disable iff (!aresetn)
      (pw_target_abort && dis[ber_pkg::EV_TABT] && ev == 8'h02) |=> pri_system_err_n)
      else $error("disabled target abort reported");
   AST_R2: assert property (@(posedge aclk) disable iff (!aresetn)
      (perr_evt.valid && perr_evt.kind == ber_pkg::BER_PW && perr_evt.upstream
       && perr_evt.on_sec && perr_evt.as_target && bctl_perr) |=> !sec_parity_err_n)
      else $error("secondary parity error missing on posted write");
   AST_R3: assert property (@(posedge aclk) disable iff (!aresetn)
      (perr_evt.valid && perr_evt.kind == ber_pkg::BER_DW && perr_evt.upstream
       && perr_evt.on_sec && perr_evt.as_target && bctl_perr) |=> !sec_parity_err_n)
      else $error("secondary parity error missing on delayed write");
   AST_R6: assert property (@(posedge aclk) disable iff (!aresetn)
      (perr_evt.valid && perr_evt.kind == ber_pkg::BER_PW && !perr_evt.as_target
       && (perr_evt.upstream != perr_evt.on_sec) && cmd_perr && bctl_perr
       && cmd[ber_pkg::CMD_SERR_EN] && !dis[ber_pkg::EV_PAR])
      |=> !pri_system_err_n && cause[ber_pkg::EV_PAR])
      else $error("posted write parity report not raised");
   AST_R8: assert property (@(posedge aclk) disable iff (!aresetn)
      (perr_evt.valid && perr_evt.kind == ber_pkg::BER_PW && !bctl_perr
       && ev[7:1] == '0) |=> pri_system_err_n)
      else $error("posted write parity error without both responses");
   AST_R11: assert property (@(posedge aclk) disable iff (!aresetn)
      (sserr_s && bctl[ber_pkg::BCTL_SERR_FWD] && cmd[ber_pkg::CMD_SERR_EN])
      |=> !pri_system_err_n && cause[ber_pkg::EV_FWD])
      else $error("secondary system error not forwarded");
   AST_R12B: assert property (@(posedge aclk) disable iff (!aresetn)
      sserr_s |=> rcv_serr)
      else $error("received flag not set from synchroniser");
   AST_R14: assert property (@(posedge aclk) disable iff (!aresetn)
      (pw_master_abort && cmd[ber_pkg::CMD_SERR_EN] && !dis[ber_pkg::EV_MABT])
      |=> !pri_system_err_n && cause[ber_pkg::EV_MABT])
      else $error("master abort not reported");
   AST_R15: assert property (@(posedge aclk) disable iff (!aresetn)
      (pw_discard && cmd[ber_pkg::CMD_SERR_EN] && !dis[ber_pkg::EV_PWDISC])
      |=> !pri_system_err_n && cause[ber_pkg::EV_PWDISC])
      else $error("posted write discard not reported");
   AST_R16: assert property (@(posedge aclk) disable iff (!aresetn)
      (dw_discard && cmd[ber_pkg::CMD_SERR_EN] && !dis[ber_pkg::EV_DWDISC])
      |=> !pri_system_err_n && cause[ber_pkg::EV_DWDISC])
      else $error("delayed write discard not reported");
   AST_R17: assert property (@(posedge aclk) disable iff (!aresetn)
      (dr_fail && cmd[ber_pkg::CMD_SERR_EN] && !dis[ber_pkg::EV_DRFAIL])
      |=> !pri_system_err_n && cause[ber_pkg::EV_DRFAIL])
      else $error("delayed read failure not reported");
   AST_R18: assert property (@(posedge aclk) disable iff (!aresetn)
      (master_timeout && cmd[ber_pkg::CMD_SERR_EN] && bctl[ber_pkg::BCTL_MTO_SERR])
      |=> !pri_system_err_n && cause[ber_pkg::EV_MTO])
      else $error("master timeout not reported");
   AST_R18B: assert property (@(posedge aclk) disable iff (!aresetn)
      (master_timeout && !bctl[ber_pkg::BCTL_MTO_SERR] && ev == 8'h00) |=> pri_system_err_n)
      else $error("master timeout reported while its enable is off");
   AST_R10B: assert property (@(posedge aclk) disable iff (!aresetn)
      !pri_system_err_n |-> sig_serr)
      else $error("system error output without signaled flag");
   AST_R19: assert property (@(posedge aclk) disable iff (!aresetn)
      !pri_system_err_n |-> cause != '0)
      else $error("system error output without recorded cause");
   AST_R22: assert property (@(posedge aclk) disable iff (!aresetn)
      (perr_evt.valid && !perr_evt.on_sec && !perr_evt.completion_rpt) |=> sec_parity_err_n)
      else $error("secondary parity error for primary-side detection");
   AST_R22B: assert property (@(posedge aclk) disable iff (!aresetn)
      (perr_evt.valid && perr_evt.on_sec && perr_evt.as_target
       && perr_evt.kind == ber_pkg::BER_RD) |=> sec_parity_err_n)
      else $error("secondary parity error as read target");
endmodule
`default_nettype wire

/* core/ber_pkg.sv */
// Package for the bridge error reporting block
// Contract
// - Secondary parity error on downstream read seen on secondary, secondary response on.
// - Secondary parity error as target of upstream posted write, secondary response on.
// - Secondary parity error as target of upstream delayed write, secondary response on.
// - Secondary parity error when upstream delayed write completion reports error, both on.
// - Target-bus parity report during posted write is a system error candidate.
// - No posted-write parity system error when bridge detected it as target.
// - Posted-write parity system error needs both parity response settings on.
// - Primary system error never asserted unless system error enable is on.
// - Each primary system error assertion sets signaled system error flag.
// - Secondary system error input forwarded to primary when forwarding enabled.
// - Seen secondary system error input sets received system error flag.
// - Posted write target abort conditionally raises primary system error.
// - Posted write master abort conditionally raises primary system error.
// - Posted write discarded after retry limit conditionally raises system error.
// - Delayed write discarded after retry limit conditionally raises system error.
// - Delayed read failing after retry limit conditionally raises system error.
// - Delayed master timeout raises system error, gated by its own control enable.
// - Cause of each primary system error recorded in a readable status register.
// - Event disable register suppresses system error per event class; master timeout and forwarded events ignore it.
// - Locks on primary and secondary proceed independently unless crossing.
// - Secondary parity error only as write target, read initiator, or delayed completion.
package ber_pkg;
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_BCTL = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_SSTAT = 8'h0C;
   localparam logic [7:0] ADDR_CAUSE = 8'h10;
   localparam logic [7:0] ADDR_DIS = 8'h14;
   // Control and status bit positions
   localparam int CMD_PERR_EN = 0;
   localparam int CMD_SERR_EN = 1;
   localparam int BCTL_PERR_EN = 0;
   localparam int BCTL_SERR_FWD = 1;
   localparam int BCTL_MTO_SERR = 2;
   localparam int STAT_SIG_SERR = 0;
   localparam int SSTAT_RCV_SERR = 0;
   // Cause bits
   localparam int EV_PAR = 0;
   localparam int EV_TABT = 1;
   localparam int EV_MABT = 2;
   localparam int EV_PWDISC = 3;
   localparam int EV_DWDISC = 4;
   localparam int EV_DRFAIL = 5;
   localparam int EV_MTO = 6;
   localparam int EV_FWD = 7;
   localparam int NEV = 8;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam int PULSE_CYC = 1;
   typedef enum logic [1:0] {
      BER_RD = 2'b00,
      BER_PW = 2'b01,
      BER_DW = 2'b10
   } ber_kind_t;
   // Parity event report from the bridge datapath
   typedef struct packed {
      logic valid;
      ber_kind_t kind;
      logic upstream;
      logic on_sec;
      logic as_target;
      logic completion_rpt;
   } ber_perr_t;
endpackage

/* verif/ber_far_end.sv */
// Far-side bus agent model driving error events into the reporting block
`timescale 1ns/1ps
`default_nettype none
module ber_far_end (
   input wire logic aclk,
   output ber_pkg::ber_perr_t perr_evt,
   output logic [5:0] ev,
   output logic sec_system_err_n
);
   initial begin
      perr_evt = '0;
      ev = 6'h00;
      sec_system_err_n = 1'b1;
   end
   // One-cycle parity report, fields left stale after valid drops
   task automatic parity(input int k, input logic up, sec, tgt, cmp);
      @(posedge aclk);
      perr_evt <= '{1'b1, ber_pkg::ber_kind_t'(k), up, sec, tgt, cmp};
      @(posedge aclk);
      perr_evt.valid <= 1'b0;
      @(negedge aclk);
   endtask
   // One-cycle abort, discard, read failure or timeout event
   task automatic pulse(input int i);
      @(posedge aclk);
      ev[i] <= 1'b1;
      @(posedge aclk);
      ev[i] <= 1'b0;
      @(negedge aclk);
   endtask
   // Secondary system error pin, pulled up when idle
   task automatic serr(input logic v);
      @(posedge aclk);
      sec_system_err_n <= v;
   endtask
endmodule
`default_nettype wire

/* verif/bridge_error_reporting_tb.sv */
// Self-checking bench for the bridge error reporting block
`timescale 1ns/1ps
`default_nettype none
module bridge_error_reporting_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   ber_pkg::ber_perr_t perr_evt;
   logic [5:0] ev;
   logic sec_system_err_n, sec_parity_err_n, pri_system_err_n;
   int miscompares = 0;
   int samples_checked = 0;
   int cycles = 0;
   ber_far_end far (.aclk(aclk), .perr_evt(perr_evt), .ev(ev), .sec_system_err_n(sec_system_err_n));
   ber_core DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .perr_evt, .pw_target_abort(ev[0]), .pw_master_abort(ev[1]),
      .pw_discard(ev[2]), .dw_discard(ev[3]), .dr_fail(ev[4]), .master_timeout(ev[5]),
      .sec_system_err_n, .sec_parity_err_n, .pri_system_err_n);
   initial begin
      forever #12.5 aclk = ~aclk;
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         conclude();
      end
   end
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      s_axi_bready <= 1'b0;
      check("bresp", er, s_axi_bresp);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      s_axi_rready <= 1'b0;
      check("rresp", er, s_axi_rresp);
      check("rdata", ed, s_axi_rdata);
   endtask
   task automatic outs(input logic es, input logic ep);
      check("sec_parity_err_n", !es, sec_parity_err_n);
      check("pri_system_err_n", !ep, pri_system_err_n);
   endtask
   task automatic row(input int k, input int u, input int s);
      logic up, sec, is_rd, dw, es, ep;
      up = u[0];
      sec = s[0];
      is_rd = (k == 0);
      dw = (k == 2);
      es = sec ? ((is_rd && !up) || (!is_rd && up)) : (dw && up);
      ep = (k == 1) && (up != sec);
      far.parity(k, up, sec, !is_rd && up && sec, dw && up && !sec);
      outs(es, ep);
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0, 2'b00);
      rd(8'h20, 32'h0, 2'b10);
      wr(ber_pkg::ADDR_CMD, 32'h3, 2'b00);
      wr(ber_pkg::ADDR_BCTL, 32'h3, 2'b00);
      for (int k = 0; k < 3; k++) for (int u = 0; u < 2; u++) for (int s = 0; s < 2; s++) row(k, u, s);
      rd(ber_pkg::ADDR_STAT, 32'h1, 2'b00);
      rd(ber_pkg::ADDR_CAUSE, 32'h1, 2'b00);
      wr(ber_pkg::ADDR_CAUSE, 32'hFF, 2'b00);
      wr(ber_pkg::ADDR_STAT, 32'h1, 2'b00);
      far.parity(1, 1'b0, 1'b1, 1'b1, 1'b0);
      outs(1'b0, 1'b0);
      wr(ber_pkg::ADDR_CMD, 32'h2, 2'b00);
      far.parity(1, 1'b1, 1'b0, 1'b0, 1'b0);
      outs(1'b0, 1'b0);
      far.parity(2, 1'b1, 1'b0, 1'b0, 1'b1);
      outs(1'b0, 1'b0);
      wr(ber_pkg::ADDR_BCTL, 32'h4, 2'b00);
      far.parity(0, 1'b0, 1'b1, 1'b0, 1'b0);
      outs(1'b0, 1'b0);
      for (int i = 0; i < 6; i++) begin
         far.pulse(i);
         outs(1'b0, 1'b1);
         rd(ber_pkg::ADDR_CAUSE, 32'h1 << (i + 1), 2'b00);
         rd(ber_pkg::ADDR_STAT, 32'h1, 2'b00);
         wr(ber_pkg::ADDR_CAUSE, 32'hFF, 2'b00);
         wr(ber_pkg::ADDR_STAT, 32'h1, 2'b00);
      end
      wr(ber_pkg::ADDR_DIS, 32'h3F, 2'b00);
      for (int i = 0; i < 6; i++) begin
         far.pulse(i);
         outs(1'b0, i == 5);
      end
      wr(ber_pkg::ADDR_BCTL, 32'h2, 2'b00);
      far.pulse(5);
      outs(1'b0, 1'b0);
      wr(ber_pkg::ADDR_CAUSE, 32'hFF, 2'b00);
      wr(ber_pkg::ADDR_STAT, 32'h1, 2'b00);
      far.serr(1'b0);
      repeat (4) @(posedge aclk);
      @(negedge aclk);
      outs(1'b0, 1'b1);
      far.serr(1'b1);
      rd(ber_pkg::ADDR_SSTAT, 32'h1, 2'b00);
      rd(ber_pkg::ADDR_CAUSE, 32'h80, 2'b00);
      wr(ber_pkg::ADDR_STAT, 32'h1, 2'b00);
      wr(ber_pkg::ADDR_CMD, 32'h0, 2'b00);
      wr(ber_pkg::ADDR_DIS, 32'h0, 2'b00);
      far.pulse(0);
      outs(1'b0, 1'b0);
      rd(ber_pkg::ADDR_STAT, 32'h0, 2'b00);
      conclude();
   end
endmodule
`default_nettype wire
